// ### design/asr_pkg.sv
// Purpose: Shared constants for the asynchronous static memory host controller
// Assumes: sys_clk at 125 MHz, fastest speed grade of the memory
// Notes: Times in ns as printed, cycle counts derived from the clock period
package asr_pkg;
    localparam int ADDR_W = 14;
    localparam int DATA_W = 4;
    localparam int SYNC_STAGES = 2;
    localparam int CLK_PERIOD_PS = 8000;

    // Memory timing, fastest grade
    localparam int T_RC_NS = 10;
    localparam int T_AA_NS = 10;
    localparam int T_AC_NS = 10;
    localparam int T_HZ_NS = 5;
    localparam int T_WC_NS = 10;
    localparam int T_CW_NS = 7;
    localparam int T_AW_NS = 7;
    localparam int T_WP_NS = 8;
    localparam int T_DW_NS = 5;

    // Least time rounded up to whole cycles, never below one
    function automatic int ns_to_cyc(input int ns);
        int c;
        c = (ns * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
        return (c < 1) ? 1 : c;
    endfunction

    function automatic int max2(input int a, input int b);
        return (a > b) ? a : b;
    endfunction

    localparam int RC_CYC = ns_to_cyc(T_RC_NS);
    localparam int ACC_CYC = max2(ns_to_cyc(T_AA_NS), ns_to_cyc(T_AC_NS));
    localparam int HZ_CYC = ns_to_cyc(T_HZ_NS);
    localparam int WC_CYC = ns_to_cyc(T_WC_NS);
    localparam int WP_CYC = max2(max2(ns_to_cyc(T_WP_NS), ns_to_cyc(T_CW_NS)),
                                 max2(ns_to_cyc(T_AW_NS), ns_to_cyc(T_DW_NS)));
    localparam int WTAIL_CYC = (WC_CYC > WP_CYC) ? WC_CYC - WP_CYC : 1;
    localparam int RD_CYC = max2(ACC_CYC, RC_CYC) + SYNC_STAGES;

    localparam int CNT_W = 4;

    typedef enum logic [4:0] {
        ST_IDLE   = 5'h01,
        ST_RD     = 5'h02,
        ST_TURN   = 5'h04,
        ST_WR     = 5'h08,
        ST_WR_END = 5'h10
    } asr_state_e;
endpackage

// ### design/asr_sync_if.sv
// Purpose: Carries the raw data pins into the synchroniser and the safe copy back
// Assumes: One clock domain on the controller side
// Notes: Raw side is asynchronous to sys_clk
`timescale 1ns/1ps
interface asr_sync_if;
    logic [asr_pkg::DATA_W-1:0] raw;
    logic [asr_pkg::DATA_W-1:0] safe;
    modport sync_side (input raw, output safe);
    modport user_side (output raw, input safe);
endinterface

// ### design/asr_in_sync.sv
// Purpose: Two flip-flop synchroniser for the memory data pins
// Assumes: Asynchronous active-low reset
// Notes: First stage is read by the second stage only
`timescale 1ns/1ps
module asr_in_sync (
    input wire logic sys_clk,
    input wire logic rstn,
    asr_sync_if.sync_side sif
);
    import asr_pkg::*;

    logic [DATA_W-1:0] meta_q;
    logic [DATA_W-1:0] safe_q;

    genvar i;
    generate
        for (i = 0; i < DATA_W; i++) begin : g_bit
            always_ff @(posedge sys_clk or negedge rstn) begin
                if (!rstn) begin
                    meta_q[i] <= 1'b0;
                    safe_q[i] <= 1'b0;
                end else begin
                    meta_q[i] <= sif.raw[i];
                    safe_q[i] <= meta_q[i];
                end
            end
        end
    endgenerate

    assign sif.safe = safe_q;
endmodule

// ### design/asr_sram_host.sv
// Purpose: Host controller running read and write cycles on a 16K x 4 static memory
// Assumes: 125 MHz sys_clk, memory of the fastest speed grade, no bus turnaround logic outside
// Notes: One request at a time; pins driven only from flip-flops
// Notes on behaviour
// - Read: select low, write strobe high
// - Address stable by select falling edge
// - Read cycle at least 10 ns
// - Write: select and write strobe both low
// - Write cycle at least 10 ns
// - Select low 7 ns before write end
// - Address stable 7 ns before write end
// - Address may change right at write end
// - Data valid 5 ns before write end, held
`timescale 1ns/1ps
module asr_sram_host (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic req_valid,
    output logic req_ready,
    input wire logic req_write,
    input wire logic [asr_pkg::ADDR_W-1:0] req_addr,
    input wire logic [asr_pkg::DATA_W-1:0] req_wdata,
    output logic rsp_valid,
    output logic [asr_pkg::DATA_W-1:0] rsp_rdata,
    output logic [asr_pkg::ADDR_W-1:0] sram_addr,
    output logic sram_ce_n,
    output logic sram_we_n,
    input wire logic [asr_pkg::DATA_W-1:0] sram_dq_i,
    output logic [asr_pkg::DATA_W-1:0] sram_dq_o,
    output logic sram_dq_oe
);
    import asr_pkg::*;

    asr_state_e state_q;
    logic [CNT_W-1:0] cnt_q;
    logic [ADDR_W-1:0] addr_q;
    logic ce_n_q;
    logic we_n_q;
    logic [DATA_W-1:0] wdata_q;
    logic oe_q;
    logic [DATA_W-1:0] rdata_q;
    logic rsp_valid_q;
    logic accept;
    logic cnt_done;

    asr_sync_if sif ();

    // Data pins are asynchronous to sys_clk
    assign sif.raw = sram_dq_i;

    asr_in_sync u_sync (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .sif(sif)
    );

    assign req_ready = (state_q == ST_IDLE);
    assign accept = req_valid && req_ready;
    assign cnt_done = (cnt_q == '0);

    // Sequencer
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            state_q <= ST_IDLE;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (accept) begin
                        state_q <= req_write ? ST_WR : ST_RD;
                    end
                end
                ST_RD: begin
                    if (cnt_done) begin
                        state_q <= ST_TURN;
                    end
                end
                ST_TURN: begin
                    // Bus must be free before a write may drive it
                    if (cnt_done) begin
                        state_q <= ST_IDLE;
                    end
                end
                ST_WR: begin
                    if (cnt_done) begin
                        state_q <= ST_WR_END;
                    end
                end
                ST_WR_END: begin
                    if (cnt_done) begin
                        state_q <= ST_IDLE;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // Phase counter
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            cnt_q <= '0;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (accept && req_write) begin
                        cnt_q <= CNT_W'(WP_CYC - 1);
                    end else if (accept) begin
                        cnt_q <= CNT_W'(RD_CYC - 1);
                    end
                end
                ST_RD: begin
                    cnt_q <= cnt_done ? CNT_W'(HZ_CYC - 1) : cnt_q - 1'b1;
                end
                ST_WR: begin
                    cnt_q <= cnt_done ? CNT_W'(WTAIL_CYC - 1) : cnt_q - 1'b1;
                end
                ST_TURN, ST_WR_END: begin
                    cnt_q <= cnt_done ? cnt_q : cnt_q - 1'b1;
                end
                default: begin
                    cnt_q <= '0;
                end
            endcase
        end
    end

    // Address held from select fall through the whole cycle
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            addr_q <= '0;
        end else if (accept) begin
            addr_q <= req_addr;
        end
    end

    // Strobes
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            ce_n_q <= 1'b1;
            we_n_q <= 1'b1;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (accept) begin
                        ce_n_q <= 1'b0;
                        we_n_q <= ~req_write;
                    end
                end
                ST_RD: begin
                    if (cnt_done) begin
                        ce_n_q <= 1'b1;
                    end
                end
                ST_WR: begin
                    // Both rise together so the memory never turns on its drivers
                    if (cnt_done) begin
                        ce_n_q <= 1'b1;
                        we_n_q <= 1'b1;
                    end
                end
                ST_TURN, ST_WR_END: begin
                    ce_n_q <= 1'b1;
                    we_n_q <= 1'b1;
                end
                default: begin
                    ce_n_q <= 1'b1;
                    we_n_q <= 1'b1;
                end
            endcase
        end
    end

    // Write data driven with the strobe fall; bus was idle beforehand
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            wdata_q <= '0;
            oe_q <= 1'b0;
        end else begin
            if (accept && req_write) begin
                wdata_q <= req_wdata;
                oe_q <= 1'b1;
            end else if (state_q == ST_WR_END && cnt_done) begin
                oe_q <= 1'b0;
            end
        end
    end

    // Read capture after access time plus synchroniser depth
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            rdata_q <= '0;
            rsp_valid_q <= 1'b0;
        end else begin
            rsp_valid_q <= 1'b0;
            if (state_q == ST_RD && cnt_done) begin
                rdata_q <= sif.safe;
                rsp_valid_q <= 1'b1;
            end
        end
    end

    assign sram_addr = addr_q;
    assign sram_ce_n = ce_n_q;
    assign sram_we_n = we_n_q;
    assign sram_dq_o = wdata_q;
    assign sram_dq_oe = oe_q;
    assign rsp_valid = rsp_valid_q;
    assign rsp_rdata = rdata_q;
endmodule

// ### test/asr_mem_model.sv
// Purpose: Behavioural 16K x 4 static memory on the controller pins
// Assumes: Delays inside the timing windows of the fastest grade
// Notes: A released bus shows inverted data, never a held value
`timescale 1ns/1ps
module asr_mem_model (
    input wire logic [13:0] sram_addr,
    input wire logic sram_ce_n,
    input wire logic sram_we_n,
    input wire logic [3:0] bus,
    output logic rd_on,
    output logic [3:0] rd_val
);
    logic [3:0] mem [0:16383];
    wire wr_on = !sram_ce_n && !sram_we_n;
    // Unknown strobes at power-up must not look like a finished write
    logic wr_was = 1'b0;
    initial begin
        for (int i = 0; i < 16384; i++) begin
            mem[i] = 4'h0;
        end
    end
    // 3 ns sits between low-Z 2 ns and the 5 and 10 ns limits
    assign #3 rd_on = !sram_ce_n && sram_we_n;
    // Same delay covers strobe release and the joint rise case
    assign #3 rd_val = mem[sram_addr];
    always @(wr_on) begin
        if (wr_was === 1'b1 && wr_on === 1'b0) begin
            mem[sram_addr] = bus;
        end
        wr_was = wr_on;
    end
endmodule

// ### test/asr_host_asserts.sv
// Purpose: Cycle-level checks on the host controller pins
// Assumes: One clock, asynchronous active-low reset
// Notes: Figures follow the walk of one read and one write
`timescale 1ns/1ps
module asr_host_asserts (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic req_valid,
    input wire logic req_ready,
    input wire logic req_write,
    input wire logic [13:0] req_addr,
    input wire logic [3:0] req_wdata,
    input wire logic rsp_valid,
    input wire logic [13:0] sram_addr,
    input wire logic sram_ce_n,
    input wire logic sram_we_n,
    input wire logic [3:0] sram_dq_o,
    input wire logic sram_dq_oe
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    wire rd_go = req_valid && req_ready && !req_write;
    wire wr_go = req_valid && req_ready && req_write;
    a_read_select: assert property (rd_go |=>
        (!sram_ce_n && sram_we_n)[*4] ##1 sram_ce_n)
        else $error("read select window wrong");
    a_read_resp: assert property (rd_go |-> ##5 rsp_valid ##1 !rsp_valid)
        else $error("read response timing wrong");
    a_write_strobe: assert property (wr_go |=> (!sram_ce_n && !sram_we_n && sram_dq_oe)
        ##1 (sram_ce_n && sram_we_n && sram_dq_oe) ##1 !sram_dq_oe)
        else $error("write strobe sequence wrong");
    a_addr_taken: assert property ((rd_go || wr_go) |=> sram_addr == $past(req_addr))
        else $error("address not taken");
    a_wdata_taken: assert property (wr_go |=> sram_dq_o == $past(req_wdata))
        else $error("write data not taken");
    a_read_no_drive: assert property (!sram_ce_n && sram_we_n |-> !sram_dq_oe)
        else $error("controller drives bus in read");
    a_write_pair: assert property (!sram_we_n |-> !sram_ce_n)
        else $error("strobe low without select");
    a_addr_steady: assert property (!sram_ce_n && $past(!sram_ce_n) |->
        $stable(sram_addr))
        else $error("address moved while selected");
    a_hold_after: assert property ($rose(sram_we_n) |->
        $stable(sram_addr) && $stable(sram_dq_o))
        else $error("address or data not held at write end");
    c_read: cover property (rd_go);
    c_write: cover property (wr_go);
    c_resp: cover property (rsp_valid);
endmodule
bind asr_sram_host asr_host_asserts asr_host_asserts_i (.sys_clk, .rstn, .req_valid, .req_ready,
    .req_write, .req_addr, .req_wdata, .rsp_valid, .sram_addr, .sram_ce_n, .sram_we_n,
    .sram_dq_o, .sram_dq_oe);

// ### test/tb_top.sv
// Purpose: Self-checking bench for the static memory host controller
// Assumes: Memory model on the pins, reference memory in an associative array
// Notes: Unwritten words read as zero since the model starts cleared
`timescale 1ns/1ps
module tb_top;
    import asr_pkg::*;
    logic sys_clk, rstn, req_valid, req_write, req_ready, rsp_valid;
    logic sram_ce_n, sram_we_n, sram_dq_oe, rd_on;
    logic [ADDR_W-1:0] req_addr, sram_addr;
    logic [DATA_W-1:0] req_wdata, rsp_rdata, sram_dq_o, sram_dq_i, rd_val;
    logic [DATA_W-1:0] ref_mem [int];
    int bad_count = 0;
    int n_compared = 0;
    int cyc = 0;
    // No pull on the data lines, so an idle bus shows inverted data
    assign sram_dq_i = sram_dq_oe ? sram_dq_o : (rd_on ? rd_val : ~rd_val);
    asr_sram_host asr_sram_host_i (.sys_clk(sys_clk), .rstn(rstn), .req_valid(req_valid),
        .req_ready(req_ready), .req_write(req_write), .req_addr(req_addr),
        .req_wdata(req_wdata), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
        .sram_addr(sram_addr), .sram_ce_n(sram_ce_n), .sram_we_n(sram_we_n),
        .sram_dq_i(sram_dq_i), .sram_dq_o(sram_dq_o), .sram_dq_oe(sram_dq_oe));
    asr_mem_model asr_mem_model_i (.sram_addr(sram_addr), .sram_ce_n(sram_ce_n),
        .sram_we_n(sram_we_n), .bus(sram_dq_i), .rd_on(rd_on), .rd_val(rd_val));
    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end
    task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic summarize();
        $display("mismatches %0d compared %0d", bad_count, n_compared);
        if (bad_count == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic issue(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        int n;
        logic [DATA_W-1:0] exp_d;
        @(posedge sys_clk);
        req_valid <= 1'b1;
        req_write <= wr;
        req_addr <= a;
        req_wdata <= d;
        do @(negedge sys_clk); while (req_ready !== 1'b1);
        @(posedge sys_clk);
        req_valid <= 1'b0;
        if (wr) begin
            ref_mem[a] = d;
        end else begin
            n = 0;
            do begin
                @(negedge sys_clk);
                n++;
                if (n == 1) check("rd_addr", {2'h0, sram_addr}, {2'h0, a});
            end while (rsp_valid !== 1'b1 && n < 10);
            check("rd_latency", 16'(n), 16'h5);
            exp_d = ref_mem.exists(a) ? ref_mem[a] : 4'h0;
            check("rd_data", {12'h0, rsp_rdata}, {12'h0, exp_d});
        end
    endtask
    // Bus clash would corrupt both read and write data
    always @(negedge sys_clk) begin
        if (rstn) check("bus_clash", {15'h0, rd_on & sram_dq_oe}, 16'h0);
    end
    // Ceiling well above some 135 cycles of traffic
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 5000) begin
            bad_count++;
            summarize();
        end
    end
    initial begin
        logic [ADDR_W-1:0] a [8];
        rstn = 1'b0;
        req_valid = 1'b0;
        req_write = 1'b0;
        req_addr = '0;
        req_wdata = '0;
        void'($urandom(32'h515344b8));
        repeat (8) @(posedge sys_clk);
        rstn <= 1'b1;
        check("idle_ce_n", {15'h0, sram_ce_n}, 16'h1);
        a[0] = 14'h0000;
        a[1] = 14'h3FFF;
        for (int i = 2; i < 8; i++) a[i] = 14'($urandom);
        issue(1'b0, a[2], 4'h0);
        foreach (a[i]) begin
            issue(1'b1, a[i], 4'($urandom));
            issue(1'b0, a[i], 4'h0);
        end
        foreach (a[i]) issue(1'b0, a[i], 4'h0);
        summarize();
    end
endmodule
